// ---- fts_pkg.sv ----
package fts_pkg;
  // register map (byte addresses, one word per register)
  localparam logic [7:0] MAXCUR_ADDR    = 8'h08; // register 02h, word index 2
  localparam logic [7:0] GPIOCTL_ADDR   = 8'h18; // register 06h, word index 6
  localparam logic [7:0] RGBCTL_ADDR    = 8'h40;
  localparam logic [7:0] SAFETY_ADDR    = 8'h44;
  localparam logic [7:0] STATUS_ADDR    = 8'h48;
  // max current fields
  localparam int RED_CUR_LSB   = 4;
  localparam int GREEN_CUR_LSB = 2;
  localparam int BLUE_CUR_LSB  = 0;
  localparam logic [1:0] CUR_FULL = 2'h3;
  localparam logic [5:0] MAXCUR_RST = 6'h00;
  // gpio control fields
  localparam int TRIG_PIN_EN_BIT = 4;
  localparam int PIN0_DIR_BIT    = 0;
  // rgb control fields
  localparam int DRV_EN_BIT    = 0;
  localparam int DIM_SEL_BIT   = 1;
  localparam int FLASH_EN_BIT  = 2;
  localparam int SWITCH_LSB    = 4;  // [6:4] = red,green,blue switch
  localparam int TRIG_SEL_LSB  = 8;  // [10:8] = red,green,blue trigger select
  // status fields
  localparam int TRIPPED_BIT   = 0;
  localparam int FLASH_ARM_BIT = 1;
  localparam int PULSE_BIT     = 2;
  // timing
  localparam int  CLK_HZ        = 25_000_000;
  localparam int  SAFETY_MS     = 1000;
  localparam int  SAFETY_CYCLES = CLK_HZ / 1000 * SAFETY_MS;
  localparam int  CNT_W         = 25;
endpackage

// ---- fts_flash_timer.sv ----
`timescale 1ns/10ps
// Function
// - in flash mode, pulse starts on trigger rise, ends on trigger fall
// - during pulse, trigger-selected outputs sink full current unless shut off by a trip on a safety-enabled channel
// - after pulse, flash-selected outputs switch off, not back to pre-flash
// - new flash needs flash enable written low then high again
// - pre-flash level follows current fields and channel switch bits
// - three per-channel safety enables; only enabled channels shut off
// - flash enable picks watchdog or pulse-length safety mode
// - flash mode off: counter runs when any safety enable is set
// - flash mode off, no trip: access to max-current register clears counter
// - at one second, safety-enabled outputs off and tripped flag set
// - flash mode on: counter counts only while trigger high
// - after trip, clearing a channel's safety enable restores it
// - after trip, only all safety enables zero clears the counter
// - max current register holds three 2-bit quarter-step fields
// - trigger pin enable forces pin 0 as input, overriding direction
module fts_flash_timer
  import fts_pkg::*;
#(
  parameter int SAFETY_COUNT = SAFETY_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        pin0_i,
  output logic             pin0_o,
  output logic             pin0_oe_n,
  output logic [1:0]       red_sink_output,
  output logic [1:0]       green_sink_output,
  output logic [1:0]       blue_sink_output,
  output logic [2:0]       sink_on
);

  logic [5:0]       maxcur_r;
  logic [4:0]       gpioctl_r;
  logic [10:0]      rgbctl_r;
  logic [2:0]       safety_en_r;
  logic [2:0]       pin0_data_r;
  logic             trig_s1_r;
  logic             trig_s2_r;
  logic             pulse_r;
  logic             armed_r;
  logic             flash_en_d_r;
  logic [2:0]       flashed_off_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             tripped_r;
  logic [2:0]       shut_r;
  logic             ack_r;
  logic [31:0]      rdata_r;

  // bus decode
  wire        req        = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wr         = req & wb_we_i & wb_sel_i[0];
  wire        wr_hi      = req & wb_we_i & wb_sel_i[1];
  wire        sel_maxcur = wb_adr_i == MAXCUR_ADDR;
  wire        sel_gpio   = wb_adr_i == GPIOCTL_ADDR;
  wire        sel_rgb    = wb_adr_i == RGBCTL_ADDR;
  wire        sel_safe   = wb_adr_i == SAFETY_ADDR;
  wire        sel_stat   = wb_adr_i == STATUS_ADDR;

  wire        flash_en       = rgbctl_r[FLASH_EN_BIT];
  wire        drv_en         = rgbctl_r[DRV_EN_BIT];
  wire [2:0]  channel_switch_bits = rgbctl_r[SWITCH_LSB +: 3];
  wire [2:0]  trig_sel       = rgbctl_r[TRIG_SEL_LSB +: 3];
  wire        trig_pin_en    = gpioctl_r[TRIG_PIN_EN_BIT];
  wire        trig_lvl       = trig_pin_en & trig_s2_r;
  wire        any_safety     = |safety_en_r;
  wire        cnt_done       = cnt_r >= CNT_W'(SAFETY_COUNT);
  wire        rgb_wr         = wr & sel_rgb;
  wire        flash_en_wr    = wb_dat_i[FLASH_EN_BIT];

  wire        pulse_start = flash_en & armed_r & trig_lvl & ~pulse_r;
  wire        pulse_end   = pulse_r & ~trig_lvl;

  wire        run_wd    = ~flash_en & any_safety;
  wire        run_flash = flash_en & any_safety & trig_lvl;
  wire        touch     = req & sel_maxcur & ~flash_en & ~tripped_r;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!any_safety && tripped_r) begin
      cnt_nxt = '0;
    end else if (touch) begin
      cnt_nxt = '0;
    end else if ((run_wd || run_flash) && !cnt_done) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end else if (!any_safety) begin
      cnt_nxt = '0;
    end
  end

  // per-channel levels: index 2 red, 1 green, 0 blue
  // quarter-step fields
  wire [1:0] lvl_r = maxcur_r[RED_CUR_LSB +: 2];
  wire [1:0] lvl_g = maxcur_r[GREEN_CUR_LSB +: 2];
  wire [1:0] lvl_b = maxcur_r[BLUE_CUR_LSB +: 2];
  logic [2:0] on_nxt;
  logic [1:0] lv_nxt [3];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      on_nxt[i] = drv_en & channel_switch_bits[i] & ~flashed_off_r[i];
      lv_nxt[i] = (i == 2) ? lvl_r : (i == 1) ? lvl_g : lvl_b;
      if (pulse_r && trig_sel[i]) begin
        on_nxt[i] = 1'b1;
        lv_nxt[i] = CUR_FULL;
      end
      if (shut_r[i] && safety_en_r[i]) begin
        on_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      maxcur_r    <= MAXCUR_RST;
      gpioctl_r   <= '0;
      rgbctl_r    <= '0;
      safety_en_r <= '0;
      pin0_data_r <= '0;
    end else begin
      if (wr && sel_maxcur) maxcur_r <= wb_dat_i[5:0];
      if (wr && sel_gpio) gpioctl_r <= wb_dat_i[4:0];
      if (wr && sel_rgb) rgbctl_r[7:0] <= wb_dat_i[7:0];
      if (wr_hi && sel_rgb) rgbctl_r[10:8] <= wb_dat_i[10:8];
      if (wr && sel_safe) safety_en_r <= wb_dat_i[2:0];
      if (wr && sel_safe) pin0_data_r <= wb_dat_i[10:8];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
    end else begin
      trig_s1_r <= pin0_i;
      trig_s2_r <= trig_s1_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_r       <= 1'b0;
      armed_r       <= 1'b0;
      flash_en_d_r  <= 1'b0;
      flashed_off_r <= '0;
    end else begin
      flash_en_d_r <= flash_en;
      if (flash_en && !flash_en_d_r) armed_r <= 1'b1;
      else if (pulse_start) armed_r <= 1'b0;
      if (pulse_start) pulse_r <= 1'b1;
      else if (pulse_end || !flash_en) pulse_r <= 1'b0;
      if (pulse_end) flashed_off_r <= flashed_off_r | trig_sel;
      else if (rgb_wr && !flash_en_wr) flashed_off_r <= '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r     <= '0;
      tripped_r <= 1'b0;
      shut_r    <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      // reloaded each cycle while saturated; restore goes through the enable mask
      // trip at one second
      if (cnt_done && any_safety) begin
        tripped_r <= 1'b1;
        shut_r    <= 3'h7;
      end else if (!any_safety) begin
        tripped_r <= 1'b0;
        shut_r    <= '0;
      end else begin
        shut_r <= shut_r & safety_en_r;
      end
    end
  end

  wire [31:0] rd_mux =
      sel_maxcur ? {26'h0, maxcur_r} :
      sel_gpio   ? {27'h0, gpioctl_r} :
      sel_rgb    ? {21'h0, rgbctl_r} :
      sel_safe   ? {21'h0, pin0_data_r, 5'h0, safety_en_r} :
      sel_stat   ? {29'h0, pulse_r, armed_r, tripped_r} : 32'h0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_r             <= 1'b0;
      rdata_r           <= '0;
      sink_on           <= '0;
      red_sink_output   <= '0;
      green_sink_output <= '0;
      blue_sink_output  <= '0;
      pin0_o            <= 1'b0;
      pin0_oe_n         <= 1'b1;
    end else begin
      ack_r             <= req;
      rdata_r           <= rd_mux;
      sink_on           <= on_nxt;
      red_sink_output   <= lv_nxt[2];
      green_sink_output <= lv_nxt[1];
      blue_sink_output  <= lv_nxt[0];
      pin0_o            <= pin0_data_r[0];
      pin0_oe_n         <= trig_pin_en | ~gpioctl_r[PIN0_DIR_BIT];
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  trip_flag_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (cnt_done && any_safety) |=> tripped_r) else $error("trip flag not set");

  trip_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (tripped_r && any_safety) |=> cnt_r == $past(cnt_r)) else $error("counter moved after trip");

  flash_full_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (pulse_r && trig_sel[2] && !(shut_r[2] && safety_en_r[2])) |=>
    sink_on[2] && red_sink_output == CUR_FULL) else $error("flash not full");

  no_rearm_a: assert property (@(posedge core_clk) disable iff (!rstn)
    pulse_end |=> !armed_r) else $error("armed after pulse");

  pulse_rise_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (flash_en && armed_r && trig_lvl && !pulse_r) |=> pulse_r)
    else $error("flash pulse did not start");

  pulse_stop_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (pulse_r && !trig_lvl) |=> !pulse_r)
    else $error("flash pulse did not end");

  flash_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (pulse_end && trig_sel[0]) |-> ##2 !sink_on[0])
    else $error("flash output not off after pulse");

  preflash_lvl_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !pulse_r |=> green_sink_output == $past(maxcur_r[GREEN_CUR_LSB +: 2]))
    else $error("pre-flash level not from field");

  wd_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (!flash_en && any_safety && !touch && !cnt_done) |=> cnt_r == $past(cnt_r) + CNT_W'(1))
    else $error("watchdog counter stalled");

  touch_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    touch |=> cnt_r == '0)
    else $error("register touch did not clear counter");

  flash_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (flash_en && !trig_lvl && any_safety) |=> $stable(cnt_r))
    else $error("counter moved with trigger low");

  shut_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (tripped_r && safety_en_r[2]) |=> !sink_on[2])
    else $error("protected output still on after trip");

  chan_restore_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (tripped_r && !safety_en_r[0] && drv_en && channel_switch_bits[0] &&
     !flashed_off_r[0]) |=> sink_on[0])
    else $error("unprotected channel not restored");

  all_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (tripped_r && !any_safety) |=> (cnt_r == '0 && !tripped_r))
    else $error("all-clear did not reset counter and flag");

  trig_input_a: assert property (@(posedge core_clk) disable iff (!rstn)
    trig_pin_en |=> pin0_oe_n)
    else $error("pin driven while trigger enabled");
endmodule

// ---- fts_host_pin.sv ----
`timescale 1ns/10ps
module fts_host_pin (
  input  wire logic trig_level,
  input  wire logic pin0_o,
  input  wire logic pin0_oe_n,
  output logic      pin_level
);
  // trigger level passes to the pin when pin0_oe_n is high, else pin0_o
  // host drives only while the device leaves the pin as input
  assign pin_level = pin0_oe_n ? trig_level : pin0_o;
endmodule

// ---- flash_trigger_safety_timer_bench.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module flash_trigger_safety_timer_bench;
  import fts_pkg::*;
  localparam int SC = 50;
  logic        core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, trig;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        wb_ack_o, pin0_i, pin0_o, pin0_oe_n;
  logic [1:0]  red_q, grn_q, blu_q;
  logic [2:0]  sink_on;
  int          bad_count, checks_done;

  fts_flash_timer #(.SAFETY_COUNT(SC)) dut (.core_clk(core_clk), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin0_i(pin0_i), .pin0_o(pin0_o), .pin0_oe_n(pin0_oe_n), .red_sink_output(red_q),
    .green_sink_output(grn_q), .blue_sink_output(blu_q), .sink_on(sink_on));
  fts_host_pin host (.trig_level(trig), .pin0_o(pin0_o), .pin0_oe_n(pin0_oe_n),
    .pin_level(pin0_i));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // no cycle limit here: a stuck slave is caught by the watchdog
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #(40 * 6000);
    bad_count++;
    stop_test();
  end

  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, trig} = '0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = 4'hf;
    tick(16);
    rstn <= 1'b1;
    `CHK(pin0_oe_n, 1'b1)
    wb(1'b1, 8'h7c, 32'hffff_ffff);
    wb(1'b0, 8'h7c, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, MAXCUR_ADDR, 32'h0);
    `CHK(rd[5:0], MAXCUR_RST)
    wb(1'b1, GPIOCTL_ADDR, 32'h1);
    wb(1'b1, SAFETY_ADDR, 32'h100);
    tick(2);
    `CHK({pin0_oe_n, pin0_o}, 2'b01)
    wb(1'b1, SAFETY_ADDR, 32'h0);
    wb(1'b1, GPIOCTL_ADDR, 32'h0);
    tick(4);
    `CHK({pin0_oe_n, pin0_o}, 2'b10)
    $display("reset and map test done");
    wb(1'b1, MAXCUR_ADDR, 32'h1b);
    wb(1'b1, RGBCTL_ADDR, 32'h51);
    tick(4);
    `CHK(sink_on, 3'b101)
    `CHK({red_q, blu_q}, 4'h7)
    $display("pre-flash test done");
    wb(1'b1, RGBCTL_ADDR, 32'h55);
    wb(1'b1, GPIOCTL_ADDR, 32'h11);
    wb(1'b1, RGBCTL_ADDR, 32'h755);
    `CHK(pin0_oe_n, 1'b1)
    wb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[2:0], 3'b010)
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        wb(1'b1, RGBCTL_ADDR, 32'h751);
        wb(1'b1, RGBCTL_ADDR, 32'h755);
      end
      trig <= 1'b1;
      tick(8);
      `CHK(sink_on, (i == 1) ? 3'b000 : 3'b111)
      if (i != 1)
        `CHK({red_q, grn_q, blu_q}, 6'h3f)
      wb(1'b0, STATUS_ADDR, 32'h0);
      `CHK(rd[2], i != 1)
      trig <= 1'b0;
      tick(8);
      `CHK(sink_on, 3'b000)
    end
    wb(1'b1, RGBCTL_ADDR, 32'h51);
    tick(4);
    `CHK(sink_on, 3'b101)
    $display("flash test done");
    wb(1'b1, SAFETY_ADDR, 32'h5);
    repeat (6) begin
      tick(30);
      wb(1'b0, MAXCUR_ADDR, 32'h0);
    end
    `CHK(sink_on, 3'b101)
    tick(SC + 10);
    `CHK(sink_on, 3'b000)
    wb(1'b0, MAXCUR_ADDR, 32'h0);
    wb(1'b1, SAFETY_ADDR, 32'h4);
    tick(4);
    `CHK(sink_on, 3'b001)
    wb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[0], 1'b1)
    wb(1'b1, SAFETY_ADDR, 32'h0);
    wb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[0], 1'b0)
    $display("watchdog test done");
    wb(1'b1, RGBCTL_ADDR, 32'h451);
    wb(1'b1, RGBCTL_ADDR, 32'h455);
    wb(1'b1, SAFETY_ADDR, 32'h4);
    tick(SC + 20);
    wb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[0], 1'b0)
    trig <= 1'b1;
    tick(SC + 20);
    `CHK(sink_on, 3'b001)
    wb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[0], 1'b1)
    trig <= 1'b0;
    wb(1'b1, SAFETY_ADDR, 32'h0);
    $display("pulse limit test done");
    stop_test();
  end
endmodule
